/* File: logic/slcu_regs.vh */
// register map, reset values and timing constants of the swing/length/count unit
// assumes a 32-bit apb slave with byte addresses in the low 8 bits
`ifndef SLCU_REGS_VH
`define SLCU_REGS_VH

`define SLCU_A_CTRL      8'h00
`define SLCU_A_SWING_AMP 8'h04
`define SLCU_A_JUMP_AMP  8'h08
`define SLCU_A_CYCLE     8'h0c
`define SLCU_A_RISE_COEF 8'h10
`define SLCU_A_TGT_LEN   8'h14
`define SLCU_A_MEAS_LEN  8'h18
`define SLCU_A_PPM       8'h1c
`define SLCU_A_FINAL     8'h20
`define SLCU_A_INTER     8'h24
`define SLCU_A_COUNT     8'h28
`define SLCU_A_IRQ_STAT  8'h2c
`define SLCU_A_IRQ_MASK  8'h30
`define SLCU_A_STATUS    8'h34

`define SLCU_CTRL_BASE_BIT 0
`define SLCU_IRQ_LEN_BIT   0
`define SLCU_IRQ_FINAL_BIT 1
`define SLCU_IRQ_INTER_BIT 2
`define SLCU_IRQ_CYCLE_BIT 3
`define SLCU_IRQ_W         4

`define SLCU_RST_BASE      1'h0
`define SLCU_RST_SWING_AMP 16'h0000
`define SLCU_RST_JUMP_AMP  16'h0000
`define SLCU_RST_CYCLE     16'h0064
`define SLCU_RST_RISE_COEF 16'h01f4
`define SLCU_RST_TGT_LEN   16'h03e8
`define SLCU_RST_PPM       16'h03e8
`define SLCU_RST_FINAL     16'h03e8
`define SLCU_RST_INTER     16'h03e8
`define SLCU_RST_IRQ_MASK  4'h0

`define SLCU_PCT_FULL      16'h03e8
`define SLCU_CLK_NS        4
`define SLCU_TICK_NS       100000

`endif

/* File: logic/slcu_swing_length_count.v */
// swing offset generator, fixed-length measurement and two-threshold pulse counter
// assumes frequency inputs come from logic on i_core_clk; pulse pins are asynchronous
`timescale 1ns/10ps
`include "slcu_regs.vh"

module slcu_swing_length_count #(
  parameter integer P_TICK_CYCLES = `SLCU_TICK_NS / `SLCU_CLK_NS
) (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_swing_en,
  input  wire [15:0] i_set_freq,
  input  wire [15:0] i_maximum_frequency,
  input  wire [15:0] i_freq_upper,
  input  wire [15:0] i_freq_lower,
  input  wire        i_fast_pulse_input,
  input  wire        i_length_reset,
  input  wire        i_count_pulse,
  input  wire        i_count_reset,
  output reg  [15:0] o_out_freq,
  output reg         o_length_reached,
  output reg         o_count_final_reached,
  output reg         o_count_inter_reached,
  output reg         o_irq
);

  localparam [31:0] TICK_LAST = P_TICK_CYCLES - 1;
  localparam        PH_RISE   = 1'b0;
  localparam        PH_FALL   = 1'b1;

  function [41:0] slcu_div;
    input [41:0] num;
    input [31:0] den;
    begin
      slcu_div = num / ((den == 32'h0) ? 42'h1 : {10'h0, den});
    end
  endfunction

  // configuration registers
  reg                       base_sel_q;
  reg  [15:0]               swing_amp_q;
  reg  [15:0]               jump_amp_q;
  reg  [15:0]               cycle_q;
  reg  [15:0]               rise_coef_q;
  reg  [15:0]               tgt_len_q;
  reg  [15:0]               ppm_q;
  reg  [15:0]               final_q;
  reg  [15:0]               inter_q;
  reg  [`SLCU_IRQ_W-1:0]    irq_mask_q;
  reg  [`SLCU_IRQ_W-1:0]    irq_stat_q;
  reg  [`SLCU_IRQ_W-1:0]    irq_stat_d;

  // synchronisers
  reg  [1:0]                lp_sync_q;
  reg  [1:0]                cp_sync_q;
  reg  [1:0]                lr_sync_q;
  reg  [1:0]                cr_sync_q;
  reg                       lp_prev_q;
  reg                       cp_prev_q;

  // swing state
  reg  [15:0]               tick_q;
  reg  [31:0]               pos_q;
  reg                       phase_q;
  reg  signed [17:0]        offset_q;
  reg  [15:0]               span_q;
  reg  [15:0]               jump_q;

  // length and count state
  reg  [31:0]               pulses_q;
  reg  [15:0]               meas_len_q;
  reg  [15:0]               count_q;

  // apb
  reg  [31:0]               rdata_d;
  reg                       map_hit;
  wire                      setup = i_psel & ~i_penable;
  wire                      wr    = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  wire                      rd_ok = i_psel & i_penable & o_pready & ~i_pwrite;

  wire                      lp_edge = lp_sync_q[1] & ~lp_prev_q;
  wire                      cp_edge = cp_sync_q[1] & ~cp_prev_q;
  wire                      len_clr = lr_sync_q[1];
  wire                      cnt_clr = cr_sync_q[1];

  // swing span and jump step
  wire [15:0]               base_f = base_sel_q ? i_maximum_frequency : i_set_freq;
  wire [41:0]               span_w = slcu_div({26'h0, base_f} * {26'h0, swing_amp_q},
                                              {16'h0, `SLCU_PCT_FULL});
  wire [41:0]               jump_w = slcu_div({26'h0, span_q} * {26'h0, jump_amp_q},
                                              {16'h0, `SLCU_PCT_FULL});

  // triangle timing in 0.1 ms ticks
  wire [31:0]               total_t = cycle_q * `SLCU_PCT_FULL;
  wire [31:0]               rise_t  = cycle_q * rise_coef_q;
  wire [31:0]               fall_t  = (rise_t >= total_t) ? 32'h0 : total_t - rise_t;
  wire [31:0]               seg_t   = (phase_q == PH_RISE) ? rise_t : fall_t;
  wire                      tick    = (tick_q == TICK_LAST[15:0]);
  wire                      seg_end = tick & (pos_q + 32'h1 >= seg_t);

  // ramp from -span+jump to +span on rise, +span-jump to -span on fall
  wire [16:0]               ramp_h  = {span_q, 1'b0} - {1'b0, jump_q};
  wire [41:0]               ramp_w  = slcu_div({25'h0, ramp_h} * {10'h0, pos_q}, seg_t - 32'h1);
  wire signed [17:0]        span_s  = {2'b00, span_q};
  wire signed [17:0]        jump_s  = {2'b00, jump_q};
  wire signed [17:0]        ramp_s  = {1'b0, ramp_w[16:0]};
  reg  signed [17:0]        offset_d;

  always @* begin
    if (!i_swing_en || span_q == 16'h0) begin
      offset_d = 18'sh0;
    end else if (phase_q == PH_RISE) begin
      offset_d = -span_s + jump_s + ramp_s;
    end else begin
      offset_d = span_s - jump_s - ramp_s;
    end
  end

  wire signed [18:0]        sum_f = {3'b000, i_set_freq} + {offset_q[17], offset_q};
  reg  [15:0]               out_d;

  always @* begin
    if (sum_f > $signed({3'b000, i_freq_upper})) begin
      out_d = i_freq_upper;
    end else if (sum_f < $signed({3'b000, i_freq_lower})) begin
      out_d = i_freq_lower;
    end else begin
      out_d = sum_f[15:0];
    end
  end

  // measured length, saturating
  wire [41:0]               len_w = slcu_div({10'h0, pulses_q} * 42'ha, {16'h0, ppm_q});
  wire [15:0]               len_d = (len_w > 42'h0ffff) ? 16'hffff : len_w[15:0];

  // interrupt events
  wire [`SLCU_IRQ_W-1:0]    ev;
  assign ev[`SLCU_IRQ_LEN_BIT]   = ~o_length_reached & ~len_clr & (meas_len_q > tgt_len_q);
  assign ev[`SLCU_IRQ_FINAL_BIT] = ~o_count_final_reached & ~cnt_clr & (count_q >= final_q);
  assign ev[`SLCU_IRQ_INTER_BIT] = ~o_count_inter_reached & ~cnt_clr & (count_q >= inter_q);
  assign ev[`SLCU_IRQ_CYCLE_BIT] = i_swing_en & seg_end & (phase_q == PH_FALL);

  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr && i_paddr == `SLCU_A_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~i_pwdata[`SLCU_IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | ev;
  end

  // read decode
  always @* begin
    rdata_d = 32'h0;
    map_hit = 1'b1;
    if (i_paddr == `SLCU_A_CTRL) begin
      rdata_d[`SLCU_CTRL_BASE_BIT] = base_sel_q;
    end else if (i_paddr == `SLCU_A_SWING_AMP) begin
      rdata_d[15:0] = swing_amp_q;
    end else if (i_paddr == `SLCU_A_JUMP_AMP) begin
      rdata_d[15:0] = jump_amp_q;
    end else if (i_paddr == `SLCU_A_CYCLE) begin
      rdata_d[15:0] = cycle_q;
    end else if (i_paddr == `SLCU_A_RISE_COEF) begin
      rdata_d[15:0] = rise_coef_q;
    end else if (i_paddr == `SLCU_A_TGT_LEN) begin
      rdata_d[15:0] = tgt_len_q;
    end else if (i_paddr == `SLCU_A_MEAS_LEN) begin
      rdata_d[15:0] = meas_len_q;
    end else if (i_paddr == `SLCU_A_PPM) begin
      rdata_d[15:0] = ppm_q;
    end else if (i_paddr == `SLCU_A_FINAL) begin
      rdata_d[15:0] = final_q;
    end else if (i_paddr == `SLCU_A_INTER) begin
      rdata_d[15:0] = inter_q;
    end else if (i_paddr == `SLCU_A_COUNT) begin
      rdata_d[15:0] = count_q;
    end else if (i_paddr == `SLCU_A_IRQ_STAT) begin
      rdata_d[`SLCU_IRQ_W-1:0] = irq_stat_q;
    end else if (i_paddr == `SLCU_A_IRQ_MASK) begin
      rdata_d[`SLCU_IRQ_W-1:0] = irq_mask_q;
    end else if (i_paddr == `SLCU_A_STATUS) begin
      rdata_d = {span_q, 12'h0, phase_q, o_count_inter_reached,
                 o_count_final_reached, o_length_reached};
    end else begin
      map_hit = 1'b0;
    end
  end

  // apb handshake: one wait-free access cycle after setup
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~map_hit;
      if (setup) begin
        o_prdata <= rdata_d;
      end else if (rd_ok) begin
        o_prdata <= 32'h0;
      end
    end
  end

  // configuration writes
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      base_sel_q  <= `SLCU_RST_BASE;
      swing_amp_q <= `SLCU_RST_SWING_AMP;
      jump_amp_q  <= `SLCU_RST_JUMP_AMP;
      cycle_q     <= `SLCU_RST_CYCLE;
      rise_coef_q <= `SLCU_RST_RISE_COEF;
      tgt_len_q   <= `SLCU_RST_TGT_LEN;
      ppm_q       <= `SLCU_RST_PPM;
      final_q     <= `SLCU_RST_FINAL;
      inter_q     <= `SLCU_RST_INTER;
      irq_mask_q  <= `SLCU_RST_IRQ_MASK;
    end else if (wr) begin
      if (i_paddr == `SLCU_A_CTRL) begin
        base_sel_q <= i_pwdata[`SLCU_CTRL_BASE_BIT];
      end else if (i_paddr == `SLCU_A_SWING_AMP) begin
        swing_amp_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_JUMP_AMP) begin
        jump_amp_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_CYCLE) begin
        cycle_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_RISE_COEF) begin
        rise_coef_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_TGT_LEN) begin
        tgt_len_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_PPM) begin
        ppm_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_FINAL) begin
        final_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_INTER) begin
        inter_q <= i_pwdata[15:0];
      end else if (i_paddr == `SLCU_A_IRQ_MASK) begin
        irq_mask_q <= i_pwdata[`SLCU_IRQ_W-1:0];
      end
    end
  end

  // pin synchronisers and edge history
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      lp_sync_q <= 2'h0;
      cp_sync_q <= 2'h0;
      lr_sync_q <= 2'h0;
      cr_sync_q <= 2'h0;
      lp_prev_q <= 1'b0;
      cp_prev_q <= 1'b0;
    end else begin
      lp_sync_q <= {lp_sync_q[0], i_fast_pulse_input};
      cp_sync_q <= {cp_sync_q[0], i_count_pulse};
      lr_sync_q <= {lr_sync_q[0], i_length_reset};
      cr_sync_q <= {cr_sync_q[0], i_count_reset};
      lp_prev_q <= lp_sync_q[1];
      cp_prev_q <= cp_sync_q[1];
    end
  end

  // triangle sequencer
  always @(posedge i_core_clk) begin
    if (i_reset || !i_swing_en) begin
      tick_q   <= 16'h0;
      pos_q    <= 32'h0;
      phase_q  <= PH_RISE;
      offset_q <= 18'sh0;
      span_q   <= 16'h0;
      jump_q   <= 16'h0;
    end else begin
      span_q   <= span_w[15:0];
      jump_q   <= jump_w[15:0];
      offset_q <= offset_d;
      tick_q   <= tick ? 16'h0 : tick_q + 16'h1;
      if (seg_end) begin
        pos_q <= 32'h0;
        if (phase_q == PH_RISE && fall_t != 32'h0) begin
          phase_q <= PH_FALL;
        end else begin
          phase_q <= PH_RISE;
        end
      end else if (tick) begin
        pos_q <= pos_q + 32'h1;
      end
    end
  end

  // length and count accumulators
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      pulses_q   <= 32'h0;
      meas_len_q <= 16'h0;
      count_q    <= 16'h0;
    end else begin
      if (len_clr) begin
        pulses_q   <= 32'h0;
        meas_len_q <= 16'h0;
      end else begin
        if (lp_edge && pulses_q != 32'hffffffff) begin
          pulses_q <= pulses_q + 32'h1;
        end
        meas_len_q <= len_d;
      end
      if (cnt_clr) begin
        count_q <= 16'h0;
      end else if (cp_edge && count_q < final_q && count_q != 16'hffff) begin
        count_q <= count_q + 16'h1;
      end
    end
  end

  // reached flags, interrupt and frequency outputs
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_length_reached      <= 1'b0;
      o_count_final_reached <= 1'b0;
      o_count_inter_reached <= 1'b0;
      irq_stat_q            <= {`SLCU_IRQ_W{1'b0}};
      o_irq                 <= 1'b0;
      o_out_freq            <= 16'h0;
    end else begin
      if (len_clr) begin
        o_length_reached <= 1'b0;
      end else if (meas_len_q > tgt_len_q) begin
        o_length_reached <= 1'b1;
      end
      if (cnt_clr) begin
        o_count_final_reached <= 1'b0;
        o_count_inter_reached <= 1'b0;
      end else begin
        if (count_q >= final_q) begin
          o_count_final_reached <= 1'b1;
        end
        if (count_q >= inter_q) begin
          o_count_inter_reached <= 1'b1;
        end
      end
      irq_stat_q <= irq_stat_d;
      o_irq      <= |(irq_stat_d & irq_mask_q);
      o_out_freq <= out_d;
    end
  end

endmodule

/* File: testbench/slcu_pulse_src.sv */
// pulse sensor model for the length and count pins
// assumes the bench raises i_go for one clock and then waits while o_busy
`timescale 1ns/10ps
module slcu_pulse_src (
  input  wire       i_core_clk,
  input  wire       i_go,
  input  wire [3:0] i_num,
  output reg        o_pin,
  output reg        o_busy
);
  int k;
  initial begin
    o_pin = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_core_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        for (k = 0; k < i_num; k++) begin
          o_pin <= 1'b1;
          repeat (2 + $urandom % 3) @(posedge i_core_clk);
          o_pin <= 1'b0;
          repeat (2 + $urandom % 3) @(posedge i_core_clk);
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/slcu_swing_length_count_asserts.sv */
// port assertions of the swing, length and count unit
// assumes fixed frequency limits and intermediate limit not above final limit
`timescale 1ns/10ps
module slcu_swing_length_count_asserts (
  input wire        i_core_clk,
  input wire        i_reset,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_swing_en,
  input wire [15:0] i_set_freq,
  input wire [15:0] i_freq_upper,
  input wire [15:0] i_freq_lower,
  input wire        i_length_reset,
  input wire        i_count_reset,
  input wire        o_pready,
  input wire [15:0] o_out_freq,
  input wire        o_length_reached,
  input wire        o_count_final_reached,
  input wire        o_count_inter_reached
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_pready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_pready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("ready without setup");
  a_out_clamp: assert property (!$past(i_reset) |->
    o_out_freq <= i_freq_upper && o_out_freq >= i_freq_lower)
    else $error("output frequency outside limits");
  a_centre_idle: assert property ((!i_swing_en && $stable(i_set_freq)) [*3] |->
    o_out_freq == (i_set_freq > i_freq_upper ? i_freq_upper :
                   i_set_freq < i_freq_lower ? i_freq_lower : i_set_freq))
    else $error("idle output not at centre");
  a_inter_first: assert property (o_count_final_reached |-> o_count_inter_reached)
    else $error("final reached before intermediate");
  a_len_clear: assert property (i_length_reset [*6] |-> !o_length_reached)
    else $error("length flag kept under reset");
  a_cnt_clear: assert property (i_count_reset [*6] |->
    !o_count_final_reached && !o_count_inter_reached)
    else $error("count flags kept under reset");
  a_final_holds: assert property ($fell(o_count_final_reached) |->
    $past(i_count_reset, 1) || $past(i_count_reset, 2) || $past(i_count_reset, 3))
    else $error("final flag dropped without clear");
  a_len_holds: assert property ($fell(o_length_reached) |->
    $past(i_length_reset, 2) || $past(i_length_reset, 3) || $past(i_length_reset, 4))
    else $error("length flag dropped without clear");
endmodule
bind slcu_swing_length_count slcu_swing_length_count_asserts u_asserts (
  .i_core_clk, .i_reset, .i_psel, .i_penable, .i_swing_en, .i_set_freq, .i_freq_upper,
  .i_freq_lower, .i_length_reset, .i_count_reset, .o_pready, .o_out_freq,
  .o_length_reached, .o_count_final_reached, .o_count_inter_reached
);

/* File: testbench/slcu_swing_length_count_tb.sv */
// self-checking bench of the swing, length and count unit
// assumes one-cycle apb access and a tick of two clocks
`timescale 1ns/10ps
`include "slcu_regs.vh"
module slcu_swing_length_count_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        swing_en = 1'b0;
  logic [15:0] set_freq = 16'h03e8;
  logic        len_rst = 1'b0;
  logic        cnt_rst = 1'b0;
  logic        len_go = 1'b0;
  logic        cnt_go = 1'b0;
  logic [3:0]  pnum = 4'h0;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [31:0] d;
  logic [15:0] rv [13] = '{16'h0000, `SLCU_RST_SWING_AMP, `SLCU_RST_JUMP_AMP, `SLCU_RST_CYCLE,
    `SLCU_RST_RISE_COEF, `SLCU_RST_TGT_LEN, 16'h0000, `SLCU_RST_PPM, `SLCU_RST_FINAL,
    `SLCU_RST_INTER, 16'h0000, 16'h0000, 16'h0000};
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  wire [31:0]  prdata;
  wire [15:0]  out_freq;
  wire         pready, pslverr, len_pin, cnt_pin, len_busy, cnt_busy;
  wire         lreach, freach, ireach, irq;
  slcu_swing_length_count #(.P_TICK_CYCLES(2)) dut (
    .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_swing_en(swing_en), .i_set_freq(set_freq),
    .i_maximum_frequency(16'h07d0), .i_freq_upper(16'h0438), .i_freq_lower(16'h0398),
    .i_fast_pulse_input(len_pin), .i_length_reset(len_rst), .i_count_pulse(cnt_pin),
    .i_count_reset(cnt_rst), .o_out_freq(out_freq), .o_length_reached(lreach),
    .o_count_final_reached(freach), .o_count_inter_reached(ireach), .o_irq(irq));
  slcu_pulse_src u_len (.i_core_clk(clk), .i_go(len_go), .i_num(pnum), .o_pin(len_pin),
    .o_busy(len_busy));
  slcu_pulse_src u_cnt (.i_core_clk(clk), .i_go(cnt_go), .i_num(pnum), .o_pin(cnt_pin),
    .o_busy(cnt_busy));
  initial forever #2 clk = ~clk;
  task automatic test_done;
    begin
      if (error_cnt == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp) begin
        error_cnt++;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      test_done;
    end
    if (psel && penable && pready) begin
      e = q.pop_front();
      chk(pslverr, e[32]);
      if (!e[33]) chk(prdata, e[31:0]);
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] x, input logic err);
    begin
      q.push_back({wr, err, x});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic pulses(input logic cnt, input logic [3:0] n);
    begin
      cnt_go <= cnt;
      len_go <= !cnt;
      pnum <= n;
      @(posedge clk);
      cnt_go <= 1'b0;
      len_go <= 1'b0;
      repeat (2) @(posedge clk);
      while (cnt_busy || len_busy) @(posedge clk);
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic clr(input logic cnt);
    begin
      cnt_rst <= cnt;
      len_rst <= !cnt;
      repeat (8) @(posedge clk);
      cnt_rst <= 1'b0;
      len_rst <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic swing(input logic [31:0] ctl, amp, coef, jmp, input int emax, emin, rise, ej);
    int mx, mn, tmx, st, pv, k;
    begin
      swing_en <= 1'b0;
      apb(1, `SLCU_A_CTRL, ctl, 0, 0);
      apb(1, `SLCU_A_SWING_AMP, amp, 0, 0);
      apb(1, `SLCU_A_RISE_COEF, coef, 0, 0);
      apb(1, `SLCU_A_JUMP_AMP, jmp, 0, 0);
      swing_en <= 1'b1;
      k = 0;
      while (out_freq !== emin && k < 5000) begin
        @(posedge clk);
        k++;
      end
      mx = 0;
      mn = 65535;
      st = 0;
      pv = out_freq;
      for (k = 0; k < 2000; k++) begin
        if (out_freq > mx) begin
          mx = out_freq;
          tmx = k;
        end
        if (out_freq < mn) mn = out_freq;
        if ((out_freq > pv ? out_freq - pv : pv - out_freq) > st) st = out_freq > pv ?
          out_freq - pv : pv - out_freq;
        pv = out_freq;
        @(posedge clk);
      end
      chk(mx, emax);
      chk(mn, emin);
      chk(st >= ej && st <= ej + 1, 1);
      if (rise > 0) chk(tmx > rise - 8 && tmx < rise + 8, 1);
    end
  endtask
  initial begin
    void'($urandom(19));
    set_freq = 16'h0384 + 16'($urandom % 400);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 13; i++) apb(0, 8'(i * 4), 0, rv[i], 0);
    apb(0, 8'h38, 0, 0, 1);
    apb(1, 8'h3c, 32'h1, 0, 1);
    apb(1, `SLCU_A_MEAS_LEN, 32'h5, 0, 0);
    apb(0, `SLCU_A_MEAS_LEN, 0, 0, 0);
    d = $urandom;
    apb(1, `SLCU_A_TGT_LEN, d, 0, 0);
    apb(0, `SLCU_A_TGT_LEN, 0, d[15:0], 0);
    apb(1, `SLCU_A_FINAL, 32'h5, 0, 0);
    apb(1, `SLCU_A_INTER, 32'h3, 0, 0);
    pulses(1, 3);
    chk({ireach, freach}, 2'b10);
    pulses(1, 2);
    chk({ireach, freach}, 2'b11);
    pulses(1, 3);
    apb(0, `SLCU_A_COUNT, 0, 5, 0);
    chk(irq, 0);
    apb(1, `SLCU_A_IRQ_MASK, 32'h6, 0, 0);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    apb(0, `SLCU_A_IRQ_STAT, 0, 32'h6, 0);
    apb(1, `SLCU_A_IRQ_STAT, 32'h6, 0, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    clr(1);
    chk({ireach, freach}, 2'b00);
    apb(0, `SLCU_A_COUNT, 0, 0, 0);
    apb(1, `SLCU_A_PPM, 32'ha, 0, 0);
    apb(1, `SLCU_A_TGT_LEN, 32'h2, 0, 0);
    pulses(0, 2);
    apb(0, `SLCU_A_MEAS_LEN, 0, 2, 0);
    chk(lreach, 0);
    pulses(0, 1);
    chk(lreach, 1);
    apb(1, `SLCU_A_PPM, 32'h1e, 0, 0);
    apb(0, `SLCU_A_MEAS_LEN, 0, 1, 0);
    chk(lreach, 1);
    clr(0);
    chk(lreach, 0);
    apb(0, `SLCU_A_MEAS_LEN, 0, 0, 0);
    set_freq <= 16'h03e8;
    apb(1, `SLCU_A_CYCLE, 32'h1, 0, 0);
    swing(0, 0, 500, 0, 1000, 1000, 0, 0);
    swing(0, 50, 250, 0, 1050, 950, 500, 0);
    swing(0, 50, 750, 0, 1050, 950, 1500, 0);
    swing(1, 50, 500, 0, 1080, 920, 0, 0);
    swing(0, 50, 500, 500, 1050, 950, 0, 25);
    apb(0, `SLCU_A_IRQ_STAT, 0, 32'h9, 0);
    test_done;
  end
endmodule
